// [rtl/sstc_defs.svh]
// Constants for the scope sweep trigger control block
`ifndef SSTC_DEFS_SVH
`define SSTC_DEFS_SVH
`define SSTC_CLK_MHZ          250
`define SSTC_FREERUN_MS       50
`define SSTC_FREERUN_CYC      (`SSTC_FREERUN_MS * 1000 * `SSTC_CLK_MHZ)
`define SSTC_SRC_INTERNAL     1'b0
`define SSTC_SRC_EXTERNAL     1'b1
`define SSTC_SLOPE_RISING     1'b0
`define SSTC_SLOPE_FALLING    1'b1
`endif

// [rtl/sstc_pkg.sv]
// Types for the scope sweep trigger control block
package sstc_pkg;
    typedef enum logic [1:0] {
        SSTC_IDLE,
        SSTC_PRE,
        SSTC_WAIT,
        SSTC_POST
    } sstc_state_e;
endpackage

// [rtl/sstc_running_mean.sv]
// Running mean accumulator with clear
`timescale 1ns/100ps
`default_nettype none
module sstc_running_mean #(
    parameter int DW = 16,
    parameter int CW = 16
) (
    // Clock and reset
    input  wire logic          i_clk_sys,
    input  wire logic          i_reset_n,
    // Control
    input  wire logic          i_clear,
    input  wire logic          i_sample_valid,
    input  wire logic [DW-1:0] i_sample,
    // Result
    output logic [DW+CW-1:0]   o_sum,
    output logic [CW-1:0]      o_count
);
    logic [DW+CW-1:0] sum_r;
    logic [CW-1:0]    count_r;
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || i_clear) begin
            sum_r   <= '0;
            count_r <= '0;
        end else if (i_sample_valid && count_r != '1) begin
            sum_r   <= sum_r + (DW+CW)'(i_sample);
            count_r <= count_r + 1'b1;
        end
    end
    assign o_sum   = sum_r;
    assign o_count = count_r;
endmodule
`default_nettype wire

// [rtl/sstc_top.sv]
// Sweep trigger and arming control for an audio scope capture
// Function
// - Auto mode with repeat arming free-runs a sweep after about 50 ms without trigger.
// - Normal mode starts a sweep only on a real qualifying trigger event.
// - Repeat arming keeps the block armed for every trigger.
// - One-shot arming arms only on the re-arm command, issued before each capture.
// - Threshold in vertical divisions applies only with the internal source.
// - Programmable pre-trigger divisions are captured ahead of the trigger point.
// - Trigger on rising or falling transition per slope setting.
// - Internal source compares input level against threshold.
// - External source triggers from the external trigger input edge.
// - Measurement reset clears running mean accumulation.
`timescale 1ns/100ps
`default_nettype none
`include "sstc_defs.svh"
module sstc_top
    import sstc_pkg::*;
#(
    parameter int DW          = 16,
    parameter int DIV_SAMPLES = 64,
    parameter int DIVS        = 10,
    parameter int FREERUN_CYC = `SSTC_FREERUN_CYC
) (
    // Clock and reset
    input  wire logic          i_clk_sys,
    input  wire logic          i_reset_n,
    // Operator settings
    input  wire logic          i_auto_mode,
    input  wire logic          i_repeat_arm,
    input  wire logic          i_rearm,
    input  wire logic          i_source_ext,
    input  wire logic          i_slope_falling,
    input  wire logic signed [7:0] i_level_div,
    input  wire logic [3:0]    i_pretrig_div,
    input  wire logic          i_meas_reset,
    // Signal inputs
    input  wire logic          i_sample_valid,
    input  wire logic signed [DW-1:0] i_sample,
    input  wire logic signed [DW-1:0] i_div_size,
    input  wire logic          i_ext_trig,
    // Status and results
    output logic               o_armed,
    output logic               o_sweep_active,
    output logic               o_sweep_start,
    output logic               o_sweep_done,
    output logic               o_triggered,
    output logic               o_auto_fired,
    output logic [15:0]        o_trig_index,
    output logic [DW+15:0]     o_mean_sum,
    output logic [15:0]        o_mean_count
);
    localparam int SWEEP = DIV_SAMPLES * DIVS;

    // Sweep sequencer
    sstc_state_e      state_r;
    sstc_state_e      state_nxt;
    logic [15:0]      cnt_r;
    logic [15:0]      cnt_nxt;

    // Free-run timer
    logic [31:0]      timer_r;
    logic [31:0]      timer_nxt;

    // Arming
    logic             armed_r;
    logic             armed_nxt;

    // Previous level of each trigger source
    logic             cmp_r;
    logic             ext_r;

    // Result pulses and trigger position
    logic             start_r;
    logic             done_r;
    logic             trig_r;
    logic             auto_r;
    logic [15:0]      tidx_r;
    logic [15:0]      tidx_nxt;

    // Threshold in sample counts; only the internal path ever looks at it
    wire logic signed [DW+7:0] thresh = i_level_div * i_div_size;
    wire logic        cmp_now    = (i_sample >= thresh);

    // Source and slope decode
    wire logic        src_ext    = (i_source_ext == `SSTC_SRC_EXTERNAL);
    wire logic        slope_fall = (i_slope_falling == `SSTC_SLOPE_FALLING);

    // Both histories update whichever source is selected, so switching source never compares
    // against a level that belongs to the other source
    wire logic        trig_sig   = src_ext ? i_ext_trig : cmp_now;
    wire logic        trig_prev  = src_ext ? ext_r : cmp_r;
    wire logic        rise       = trig_sig && !trig_prev;
    wire logic        fall       = !trig_sig && trig_prev;

    // An internal edge only counts on a valid sample; between samples the
    // sample bus may hold anything
    wire logic        sig_fresh  = src_ext || i_sample_valid;
    wire logic        edge_ev    = sig_fresh && (slope_fall ? fall : rise);

    // Pre-trigger span in samples; the trigger lands this far into the record
    wire logic [15:0] pre_len    = 16'(i_pretrig_div) * 16'(DIV_SAMPLES);
    wire logic        pre_full   = (cnt_r >= pre_len);

    // State decode
    wire logic        in_idle    = (state_r == SSTC_IDLE);
    wire logic        in_wait    = (state_r == SSTC_WAIT);
    wire logic        in_post    = (state_r == SSTC_POST);

    // Free-run only with auto mode and repeat arming together
    wire logic        timeout    = i_auto_mode && i_repeat_arm
                                   && (timer_r >= 32'(FREERUN_CYC));

    // A real edge always wins over the timer in the same cycle
    wire logic        fire_trig  = armed_r && in_wait && edge_ev;
    wire logic        fire_auto  = armed_r && in_wait && !edge_ev && timeout;
    wire logic        fire_any   = fire_trig || fire_auto;

    // The sweep record holds exactly SWEEP valid samples
    wire logic        post_last  = (cnt_r == 16'(SWEEP - 1));
    wire logic        post_end   = in_post && i_sample_valid && post_last;

    // Only samples of a running sweep feed the running mean
    wire logic        mean_take  = i_sample_valid && in_post;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SSTC_IDLE: if (armed_r) state_nxt = SSTC_PRE;
            SSTC_PRE:  if (pre_full) state_nxt = SSTC_WAIT;
            SSTC_WAIT: if (fire_any) state_nxt = SSTC_POST;
            SSTC_POST: if (post_end) state_nxt = SSTC_IDLE;
        endcase
    end

    // Count restarts on every state change, so each phase counts its own samples
    always_comb begin
        cnt_nxt = cnt_r;
        if (state_nxt != state_r) begin
            cnt_nxt = '0;
        end else if (i_sample_valid && cnt_r != '1) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // Timer measures time since the sequencer last left idle; it saturates, so a very
    // long wait can never wrap back below the free-run limit
    always_comb begin
        timer_nxt = timer_r;
        if (in_post || in_idle) begin
            timer_nxt = '0;
        end else if (timer_r != '1) begin
            timer_nxt = timer_r + 1'b1;
        end
    end

    // A re-arm in the cycle of the one-shot disarm wins, so it is never lost
    always_comb begin
        armed_nxt = armed_r;
        if (i_repeat_arm) begin
            armed_nxt = 1'b1;
        end else if (i_rearm) begin
            armed_nxt = 1'b1;
        end else if (post_end) begin
            armed_nxt = 1'b0;
        end
    end

    assign tidx_nxt = fire_any ? pre_len : tidx_r;

    // Sequencer and sample count
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_r <= SSTC_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Free-run timer
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            timer_r <= '0;
        end else begin
            timer_r <= timer_nxt;
        end
    end

    // Arming
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= armed_nxt;
        end
    end

    // Source history; the compare only moves on valid samples
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cmp_r <= 1'b0;
            ext_r <= 1'b0;
        end else begin
            if (i_sample_valid) cmp_r <= cmp_now;
            ext_r <= i_ext_trig;
        end
    end

    // One-cycle result pulses
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            start_r <= 1'b0;
            done_r  <= 1'b0;
            trig_r  <= 1'b0;
            auto_r  <= 1'b0;
        end else begin
            start_r <= fire_any;
            done_r  <= post_end;
            trig_r  <= fire_trig;
            auto_r  <= fire_auto;
        end
    end

    // Trigger position inside the record
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            tidx_r <= '0;
        end else begin
            tidx_r <= tidx_nxt;
        end
    end

    // Measurement reset empties the running mean
    sstc_running_mean #(.DW(DW), .CW(16)) u_mean (
        .i_clk_sys      (i_clk_sys),
        .i_reset_n      (i_reset_n),
        .i_clear        (i_meas_reset),
        .i_sample_valid (mean_take),
        .i_sample       (i_sample),
        .o_sum          (o_mean_sum),
        .o_count        (o_mean_count)
    );

    assign o_armed        = armed_r;
    assign o_sweep_active = (state_r == SSTC_POST);
    assign o_sweep_start  = start_r;
    assign o_sweep_done   = done_r;
    assign o_triggered    = trig_r;
    assign o_auto_fired   = auto_r;
    assign o_trig_index   = tidx_r;
endmodule
`default_nettype wire

// [test/sstc_trig_src.sv]
// External trigger source that drives one qualifying edge per request
`timescale 1ns/100ps
`default_nettype none
module sstc_trig_src (
    input  wire logic i_clk_sys,
    input  wire logic i_fire,
    input  wire logic i_slope_falling,
    output logic      o_ext_trig = 1'b0
);
    // Idle level is the opposite of the edge wanted, so a request is one clean edge
    always @(posedge i_clk_sys) o_ext_trig <= i_fire ^ i_slope_falling;
endmodule
`default_nettype wire

// [test/sstc_top_props.sv]
// Port assertions for the sweep trigger control
`timescale 1ns/100ps
`default_nettype none
module sstc_top_props #(parameter int DIV_SAMPLES = 64) (
    input wire logic        i_clk_sys, i_reset_n, i_auto_mode, i_repeat_arm, i_meas_reset,
    input wire logic [3:0]  i_pretrig_div,
    input wire logic        o_armed, o_sweep_active, o_sweep_start, o_sweep_done,
    input wire logic        o_triggered, o_auto_fired,
    input wire logic [15:0] o_trig_index, o_mean_count
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    a_start_armed: assert property (o_sweep_start |-> $past(o_armed))
        else $error("start while disarmed");
    a_auto_cause: assert property (o_auto_fired |-> $past(i_auto_mode && i_repeat_arm))
        else $error("free-run outside auto repeat");
    a_norm_trig: assert property (o_sweep_start && !$past(i_auto_mode) |-> o_triggered)
        else $error("normal start without trigger");
    a_single_disarm: assert property (o_sweep_done && !i_repeat_arm |-> ##[0:1] !o_armed)
        else $error("still armed after one-shot");
    a_trig_index: assert property (o_triggered |->
        ##[0:1] o_trig_index == 16'(i_pretrig_div * DIV_SAMPLES))
        else $error("trigger index wrong");
    a_mean_clear: assert property (i_meas_reset |=> o_mean_count == 16'h0000)
        else $error("mean not cleared");
    a_start_active: assert property (o_sweep_start |-> ##[0:1] o_sweep_active)
        else $error("sweep not running");
    a_repeat_armed: assert property (i_repeat_arm && $past(i_repeat_arm && o_armed) |-> o_armed)
        else $error("repeat lost arming");
endmodule
bind sstc_top sstc_top_props #(.DIV_SAMPLES(DIV_SAMPLES)) i_sstc_top_props (.i_clk_sys,
    .i_reset_n, .i_auto_mode, .i_repeat_arm, .i_meas_reset, .i_pretrig_div, .o_armed,
    .o_sweep_active, .o_sweep_start, .o_sweep_done, .o_triggered, .o_auto_fired,
    .o_trig_index, .o_mean_count);
`default_nettype wire

// [test/scope_sweep_trigger_control_tb.sv]
// Self-checking bench for the sweep trigger control
`timescale 1ns/100ps
`default_nettype none
module scope_sweep_trigger_control_tb;
    logic               i_clk_sys = 0, i_reset_n = 0, i_auto_mode = 0, i_repeat_arm = 0;
    logic               i_rearm = 0, i_source_ext = 1, i_slope_falling = 0, i_meas_reset = 0;
    logic               i_sample_valid = 1, i_ext_trig, fire = 0, q = 0;
    logic signed [7:0]  i_level_div = 8'sh02;
    logic [3:0]         i_pretrig_div = 4'h3;
    logic signed [15:0] i_sample = 16'sh0000, i_div_size = 16'sh0010;
    logic               o_armed, o_sweep_active, o_sweep_start, o_sweep_done;
    logic               o_triggered, o_auto_fired;
    logic [15:0]        o_trig_index, o_mean_count;
    logic [31:0]        o_mean_sum;
    int                 num_errors = 0, cmp_count = 0;
    sstc_top #(.DIV_SAMPLES(2), .DIVS(2), .FREERUN_CYC(100)) i_sstc_top (.i_clk_sys, .i_reset_n,
        .i_auto_mode, .i_repeat_arm, .i_rearm, .i_source_ext, .i_slope_falling, .i_level_div,
        .i_pretrig_div, .i_meas_reset, .i_sample_valid, .i_sample, .i_div_size, .i_ext_trig,
        .o_armed, .o_sweep_active, .o_sweep_start, .o_sweep_done, .o_triggered,
        .o_auto_fired, .o_trig_index, .o_mean_sum, .o_mean_count);
    sstc_trig_src i_sstc_trig_src (.i_clk_sys, .i_fire(fire), .i_slope_falling,
        .o_ext_trig(i_ext_trig));
    initial forever #2 i_clk_sys = ~i_clk_sys;
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("Errors %0d in %0d checks", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic arm();
        @(posedge i_clk_sys) i_rearm <= 1;
        @(posedge i_clk_sys) i_rearm <= 0;
        tick(12);
    endtask
    // Drives one qualifying edge on the external line and raises the sampled level, then watches for a start
    task automatic shot(logic exp);
        logic got = 0;
        @(posedge i_clk_sys) fire <= 1;
        i_sample <= 16'sh0064;
        repeat (30) begin
            @(negedge i_clk_sys);
            got |= o_sweep_start;
        end
        check("start", 16'(got), 16'(exp));
        if (exp) check("index", o_trig_index, 16'h0006);
        @(posedge i_clk_sys) fire <= 0;
        i_sample <= 16'sh0000;
    endtask
    initial begin
        void'($urandom(32'he96526ce));
        tick(6);
        i_reset_n <= 1;
        for (int s = 0; s < 2; s++) begin
            i_slope_falling <= s[0];
            arm();
            shot(1);
        end
        @(negedge i_clk_sys) check("armed", 16'(o_armed), 16'h0000);
        shot(0);
        @(negedge i_clk_sys) check("mean count", o_mean_count, 16'h0008);
        @(posedge i_clk_sys) i_meas_reset <= 1;
        @(posedge i_clk_sys) i_meas_reset <= 0;
        @(negedge i_clk_sys) check("mean", o_mean_count, 16'h0000);
        @(posedge i_clk_sys) i_source_ext <= 0;
        i_slope_falling <= 0;
        arm();
        repeat (20) begin
            @(posedge i_clk_sys) i_sample <= 16'($urandom % 32);
            @(negedge i_clk_sys) q |= o_sweep_start;
        end
        check("quiet", 16'(q), 16'h0000);
        shot(1);
        i_source_ext <= 1;
        i_repeat_arm <= 1;
        tick(12);
        shot(1);
        shot(1);
        i_auto_mode <= 1;
        q = 0;
        repeat (300) @(negedge i_clk_sys) q |= o_auto_fired;
        check("auto", 16'(q), 16'h0001);
        close_out();
    end
endmodule
`default_nettype wire
